// ===== pkg/pcr_pkg.sv
// ==========================================
// Periodic collection register constants
// ==========================================
package pcr_pkg;
    // Frame address offsets within a channel
    localparam logic [6:0] OFS_SAMPLE0 = 7'h02;
    localparam logic [6:0] SMP_STRIDE = 7'h02;
    localparam int SMP_SLOTS = 4;
    localparam logic [6:0] OFS_PERIODIC_COLLECTION_MODE = 7'h0a;
    localparam logic [6:0] OFS_CHCTRL = 7'h0b;
    localparam logic [6:0] OFS_CLEAR = 7'h0e;
    localparam logic [6:0] CH0_BASE = 7'h00;

    // Periodic control byte fields
    localparam int PC_BRC_BIT = 7;
    localparam int PC_AUTO_BIT = 1;
    localparam int PC_EN_BIT = 0;

    // Channel control byte fields
    localparam int CC_TEST_BIT = 3;
    localparam int CC_EN_BIT = 2;
    localparam int CC_BCK_LSB = 0;
    localparam logic [1:0] BCK_ALL = 2'h3;

    // Status byte fields
    localparam int ST_PLL_BIT = 7;
    localparam int ST_REF_BIT = 6;
    localparam int ST_GNDA_BIT = 5;
    localparam int ST_GNDD_BIT = 4;
    localparam int ST_OCS_BIT = 3;
    localparam int ST_TS_BIT = 2;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_UV_BIT = 0;
    localparam logic [7:0] ST_W0C_MASK = 8'hfd;

    // Sample top byte fields (within the 24-bit readback)
    localparam int SMP_ERR_BIT = 23;
    localparam int SMP_RNE_BIT = 21;
    localparam int SMP_UV_BIT = 20;

    // Reset values and keys
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CLEAR_KEY = 8'hff;

    // Timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BRC_STEP_PS = 500000;
    localparam int BRC_STEP_CYC = (BRC_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AUTO_PERIOD_US = 500;
    localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_US * 1000000 / CLK_PERIOD_PS;
    localparam int TMR_W = 14;

    // Channel mode, Gray along normal -> periodic -> buffer check
    typedef enum logic [1:0] {
        MODE_CMDRESP = 2'b00,
        MODE_PERIODIC = 2'b01,
        MODE_BUFCHK = 2'b11
    } pcr_mode_t;
endpackage

// ===== logic/pcr_bcast_timer.sv
`timescale 1ns/100ps
// ==========================================
// Broadcast read delay timer
// ==========================================
module pcr_bcast_timer import pcr_pkg::*; #(
    parameter int STEP_CYC = BRC_STEP_CYC
) (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    input logic ce,
    // Request
    input logic clr,
    input logic trig,
    input logic [7:0] delay,
    // Result
    output logic busy,
    output logic send
);
    typedef struct packed {
        logic busy;
        logic [TMR_W-1:0] cnt;
        logic send;
    } pcr_tmr_t;

    pcr_tmr_t s_r;
    pcr_tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.send = 1'b0;
        if (s_r.busy) begin
            if (s_r.cnt == '0) begin
                s_nxt.busy = 1'b0;
                s_nxt.send = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end else if (trig) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = TMR_W'(delay) * TMR_W'(STEP_CYC);
        end
        if (clr) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign send = s_r.send;

    // ==========================================
    // Checks
    // ==========================================
    property p_load;
        @(posedge clk_sys) disable iff (sys_rst)
        ce && trig && !s_r.busy && !clr |=> s_r.busy && s_r.cnt == TMR_W'($past(delay)) * TMR_W'(STEP_CYC);
    endproperty
    a_load: assert property (p_load) else $error("delay count not loaded");

    property p_expire;
        @(posedge clk_sys) disable iff (sys_rst)
        ce && s_r.busy && s_r.cnt == '0 && !clr |=> send && !s_r.busy;
    endproperty
    a_expire: assert property (p_expire) else $error("send missing at expiry");
endmodule

// ===== logic/pcr_sample_slot.sv
`timescale 1ns/100ps
// ==========================================
// One slave sample buffer
// ==========================================
module pcr_sample_slot import pcr_pkg::*; (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    input logic ce,
    // Control
    input logic clr,
    input logic consume,
    // Engine write
    input logic wr_en,
    input logic [19:0] wr_data,
    input logic wr_err,
    input logic wr_uv,
    // Readback, top, mid, low bytes
    output logic [23:0] rb
);
    typedef struct packed {
        logic [19:0] data;
        logic err;
        logic rx_not_empty;
        logic uv;
    } pcr_slot_t;

    pcr_slot_t s_r;
    pcr_slot_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (consume) begin
            s_nxt.rx_not_empty = 1'b0;
        end
        if (clr) begin
            s_nxt = '0;
        end
        if (wr_en) begin
            s_nxt.data = wr_data;
            s_nxt.err = wr_err;
            s_nxt.uv = wr_uv;
            s_nxt.rx_not_empty = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rb = {s_r.err, 1'b0, s_r.rx_not_empty, s_r.uv, s_r.data};

    // ==========================================
    // Checks
    // ==========================================
    property p_store;
        @(posedge clk_sys) disable iff (sys_rst)
        ce && wr_en |=> rb[19:0] == $past(wr_data) && rb[SMP_RNE_BIT];
    endproperty
    a_store: assert property (p_store) else $error("sample not stored");

    property p_err;
        @(posedge clk_sys) disable iff (sys_rst)
        ce && wr_en |=> rb[SMP_ERR_BIT] == $past(wr_err) && rb[SMP_UV_BIT] == $past(wr_uv);
    endproperty
    a_err: assert property (p_err) else $error("error or supply flag wrong");

    property p_consume;
        @(posedge clk_sys) disable iff (sys_rst)
        ce && consume && !wr_en |=> !rb[SMP_RNE_BIT];
    endproperty
    a_consume: assert property (p_consume) else $error("not-empty kept after read");
endmodule

// ===== logic/pcr_regs.sv
`timescale 1ns/100ps
// ==========================================
// Periodic collection channel registers
// ==========================================
// Behaviour
// - Manual read only when enabled, not auto
// - Auto broadcast read every 500 us
// - Auto bit write ignored when disabled
// - Periodic mode blocks transfers and config
// - Enable leaves only by channel clear
// - Broadcast delayed by delay times step
// - Store 20-bit sample per slave slot
// - Error flag in top byte bit 7
// - Not-empty flag until sample read
// - Supply low flag in top byte bit 4
// - Status byte diag flags, bit 1 zero
// - Buffer check beats enable and discovery
// - Discovery count write with enable set starts pulses
// - Diag flag holds until zero written
// - Supply test forces supply low flag
module pcr_regs import pcr_pkg::*; #(
    parameter logic [6:0] CH_BASE = CH0_BASE,
    parameter int AUTO_CYC = AUTO_PERIOD_CYC,
    parameter int STEP_CYC = BRC_STEP_CYC
) (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    input logic ce,
    // Host register frame
    input logic frame_valid,
    input logic frame_wr,
    input logic [6:0] frame_addr,
    input logic [23:0] frame_wdata,
    output logic [23:0] rd_data,
    output logic rd_valid,
    // Bus engine sample write
    input logic smp_wr,
    input logic [1:0] smp_slot,
    input logic [19:0] smp_data,
    input logic smp_err,
    input logic smp_uv,
    input logic bufchk_done,
    // Diagnostic events
    input logic evt_pll_unlock,
    input logic evt_ref_clock,
    input logic evt_gnda_open,
    input logic evt_gndd_open,
    input logic evt_overcurrent,
    input logic evt_thermal,
    input logic evt_supply_low,
    // Engine control
    output logic bcast_send,
    output logic periodic_mode,
    output logic channel_enable,
    output logic bufchk_start,
    output logic disc_start,
    output logic [2:0] disc_count,
    output logic supply_force_low
);
    localparam int AW = $clog2(AUTO_CYC + 1);

    typedef struct packed {
        logic broadcast_read_command;
        logic auto_rd;
        logic periodic_collection_mode_en;
        logic [7:0] dly;
        logic test;
        logic en;
        logic [1:0] buffer_check_request;
        logic [2:0] discovery_pulse_count;
        logic [7:0] stat;
        pcr_mode_t mode;
        logic [AW-1:0] auto_cnt;
        logic [23:0] rd_data;
        logic rd_valid;
        logic bufchk_start;
        logic disc_start;
    } pcr_regs_t;

    pcr_regs_t s_r;
    pcr_regs_t s_nxt;

    logic [6:0] ofs;
    logic wr;
    logic rd;
    logic wr_periodic_collection_mode;
    logic wr_chctrl;
    logic clear_hit;
    logic locked;
    logic man_trig;
    logic auto_trig;
    logic tmr_busy;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] ev;
    logic [23:0] slot_rb [SMP_SLOTS];
    logic [SMP_SLOTS-1:0] slot_hit;

    assign ofs = frame_addr - CH_BASE;
    assign wr = frame_valid && frame_wr;
    assign rd = frame_valid && !frame_wr;
    assign b2 = frame_wdata[23:16];
    assign b3 = frame_wdata[15:8];
    assign b4 = frame_wdata[7:0];
    assign wr_periodic_collection_mode = wr && ofs == OFS_PERIODIC_COLLECTION_MODE;
    assign wr_chctrl = wr && ofs == OFS_CHCTRL;
    assign clear_hit = wr && ofs == OFS_CLEAR && b2 == CLEAR_KEY;
    assign locked = s_r.mode == MODE_PERIODIC;

    assign man_trig = wr_periodic_collection_mode && b2[PC_BRC_BIT] && s_r.periodic_collection_mode_en && !s_r.auto_rd;
    assign auto_trig = s_r.auto_rd && locked && s_r.auto_cnt == AW'(AUTO_CYC - 1);

    assign ev = {evt_pll_unlock, evt_ref_clock, evt_gnda_open, evt_gndd_open,
                 evt_overcurrent, evt_thermal, 1'b0, evt_supply_low || s_r.test};

    // ==========================================
    // Sample buffers
    // ==========================================
    genvar gi;
    generate
        for (gi = 0; gi < SMP_SLOTS; gi++) begin : g_slot
            assign slot_hit[gi] = ofs == OFS_SAMPLE0 + SMP_STRIDE * 7'(gi);
            pcr_sample_slot u_slot (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .ce(ce),
                .clr(clear_hit),
                .consume(rd && slot_hit[gi]),
                .wr_en(smp_wr && smp_slot == 2'(gi)),
                .wr_data(smp_data),
                .wr_err(smp_err),
                .wr_uv(smp_uv),
                .rb(slot_rb[gi])
            );
        end
    endgenerate

    pcr_bcast_timer #(
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .clr(clear_hit),
        .trig(man_trig || auto_trig),
        .delay(s_r.dly),
        .busy(tmr_busy),
        .send(bcast_send)
    );

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_valid = rd;
        s_nxt.bufchk_start = 1'b0;
        s_nxt.disc_start = 1'b0;
        if (s_r.auto_rd && locked) begin
            s_nxt.auto_cnt = auto_trig ? '0 : s_r.auto_cnt + 1'b1;
        end else begin
            s_nxt.auto_cnt = '0;
        end
        if (wr_periodic_collection_mode) begin
            s_nxt.broadcast_read_command = b2[PC_BRC_BIT];
            if (s_r.periodic_collection_mode_en) begin
                s_nxt.auto_rd = b2[PC_AUTO_BIT];
            end
            s_nxt.periodic_collection_mode_en = s_r.periodic_collection_mode_en || b2[PC_EN_BIT];
            if (!locked) begin
                s_nxt.dly = b3;
            end
        end
        if (wr_chctrl && !locked) begin
            s_nxt.test = b2[CC_TEST_BIT];
            s_nxt.buffer_check_request = b2[CC_BCK_LSB +: 2];
            if (b2[CC_BCK_LSB +: 2] == BCK_ALL) begin
                s_nxt.bufchk_start = 1'b1;
            end else begin
                s_nxt.en = b2[CC_EN_BIT];
                s_nxt.discovery_pulse_count = b3[2:0];
                s_nxt.disc_start = b2[CC_EN_BIT] && b3[2:0] != 3'h0;
            end
        end
        if (wr_chctrl) begin
            s_nxt.stat = s_r.stat & (b4 | ~ST_W0C_MASK);
        end
        if (clear_hit) begin
            s_nxt.broadcast_read_command = 1'b0;
            s_nxt.auto_rd = 1'b0;
            s_nxt.periodic_collection_mode_en = 1'b0;
            s_nxt.dly = REG_RESET;
            s_nxt.test = 1'b0;
            s_nxt.en = 1'b0;
            s_nxt.buffer_check_request = 2'h0;
            s_nxt.discovery_pulse_count = 3'h0;
            s_nxt.stat = REG_RESET;
            s_nxt.auto_cnt = '0;
            s_nxt.bufchk_start = 1'b0;
            s_nxt.disc_start = 1'b0;
        end
        s_nxt.stat = (s_nxt.stat | ev) & ST_W0C_MASK;
        if (s_nxt.periodic_collection_mode_en) begin
            s_nxt.mode = MODE_PERIODIC;
        end else if (s_nxt.bufchk_start) begin
            s_nxt.mode = MODE_BUFCHK;
        end else if (clear_hit || (s_r.mode == MODE_BUFCHK && bufchk_done)) begin
            s_nxt.mode = MODE_CMDRESP;
        end
        s_nxt.rd_data = 24'h000000;
        for (int i = 0; i < SMP_SLOTS; i++) begin
            if (slot_hit[i]) begin
                s_nxt.rd_data = slot_rb[i];
            end
        end
        unique case (1'b1)
            ofs == OFS_PERIODIC_COLLECTION_MODE: begin
                s_nxt.rd_data = {s_r.broadcast_read_command, 5'h00, s_r.auto_rd, s_r.periodic_collection_mode_en, s_r.dly, REG_RESET};
            end
            ofs == OFS_CHCTRL: begin
                s_nxt.rd_data = {4'h0, s_r.test, s_r.en, s_r.buffer_check_request, 5'h00, s_r.discovery_pulse_count, s_r.stat};
            end
            default: begin
            end
        endcase
        if (!rd) begin
            s_nxt.rd_data = s_r.rd_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rd_data;
    assign rd_valid = s_r.rd_valid;
    assign periodic_mode = s_r.periodic_collection_mode_en;
    assign channel_enable = s_r.en;
    assign bufchk_start = s_r.bufchk_start;
    assign disc_start = s_r.disc_start;
    assign disc_count = s_r.discovery_pulse_count;
    assign supply_force_low = s_r.test;

    // ==========================================
    // Checks
    // ==========================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_manual;
        (ce && man_trig && s_r.dly == 8'h00 && !tmr_busy) ##1 (ce && !clear_hit) |=> bcast_send;
    endproperty
    a_manual: assert property (p_manual) else $error("manual read not sent");

    property p_no_manual;
        ce && wr_periodic_collection_mode && !s_r.periodic_collection_mode_en && !tmr_busy |=> !tmr_busy;
    endproperty
    a_no_manual: assert property (p_no_manual) else $error("read sent while disabled");

    property p_auto;
        ce && auto_trig && !tmr_busy && !clear_hit |=> tmr_busy && s_r.auto_cnt == '0;
    endproperty
    a_auto: assert property (p_auto) else $error("auto read not started");

    property p_auto_lock;
        ce && wr_periodic_collection_mode && !s_r.periodic_collection_mode_en |=> s_r.auto_rd == $past(s_r.auto_rd);
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("auto bit changed while disabled");

    property p_cfg_lock;
        ce && locked && wr_chctrl |=> channel_enable == $past(channel_enable) && !disc_start;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config changed in periodic mode");

    property p_en_sticky;
        ce && s_r.periodic_collection_mode_en && !clear_hit |=> s_r.periodic_collection_mode_en && periodic_mode;
    endproperty
    a_en_sticky: assert property (p_en_sticky) else $error("periodic mode left without clear");

    property p_stat;
        ce && wr_chctrl && b4[ST_PLL_BIT] && !evt_pll_unlock |=> s_r.stat[ST_PLL_BIT] == $past(s_r.stat[ST_PLL_BIT]);
    endproperty
    a_stat: assert property (p_stat) else $error("flag changed by writing one");

    property p_set_wins;
        ce && evt_thermal |=> s_r.stat[ST_TS_BIT] && !s_r.stat[ST_ZERO_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("thermal event lost");

    property p_bck;
        ce && wr_chctrl && !locked && b2[CC_BCK_LSB +: 2] == BCK_ALL && !clear_hit
            |=> bufchk_start && channel_enable == $past(channel_enable);
    endproperty
    a_bck: assert property (p_bck) else $error("buffer check lost priority");

    property p_test;
        ce && s_r.test |=> s_r.stat[ST_UV_BIT] && (supply_force_low || $past(wr_chctrl) || $past(clear_hit));
    endproperty
    a_test: assert property (p_test) else $error("supply test flag missing");

    property p_clear;
        ce && clear_hit |=> s_r.stat == (8'h00 | ($past(ev) & ST_W0C_MASK)) && !s_r.periodic_collection_mode_en;
    endproperty
    a_clear: assert property (p_clear) else $error("channel clear incomplete");

    c_manual: cover property (ce && man_trig ##[1:300] bcast_send);
    c_auto: cover property (ce && auto_trig);
    c_bufchk: cover property (bufchk_start);
    c_clear: cover property (ce && clear_hit && s_r.periodic_collection_mode_en);
endmodule

// ===== bench/pcr_host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host register frame model
// ==========================================
module pcr_host_model import pcr_pkg::*; (
    // Clock
    input logic clk_sys,
    // Frame to device
    output logic frame_valid,
    output logic frame_wr,
    output logic [6:0] frame_addr,
    output logic [23:0] frame_wdata,
    // Read answer
    input logic [23:0] rd_data,
    input logic rd_valid
);
    initial begin
        frame_valid = 1'b0;
        frame_wr = 1'b0;
        frame_addr = 7'h7f;
        frame_wdata = 24'h5a5a5a;
    end

    task automatic send(input logic wr, input logic [6:0] addr, input logic [23:0] data);
        @(posedge clk_sys);
        #1;
        frame_valid = 1'b1;
        frame_wr = wr;
        frame_addr = addr;
        frame_wdata = data;
        @(posedge clk_sys);
        #1;
        frame_valid = 1'b0;
        frame_wr = ~wr;
        frame_addr = ~addr;
        frame_wdata = ~data;
    endtask

    task automatic wr(input logic [6:0] addr, input logic [23:0] data);
        send(1'b1, addr, data);
    endtask

    // Answer is registered at the taking edge
    task automatic rd(input logic [6:0] addr, output logic [23:0] data, output logic ok);
        send(1'b0, addr, 24'h000000);
        ok = rd_valid;
        data = rd_data;
    endtask
endmodule

// ===== bench/pcr_regs_bench.sv
`timescale 1ns/100ps
// ==========================================
// Register slice bench
// ==========================================
module pcr_regs_bench import pcr_pkg::*; ;
    localparam int AUTO_T = 50;
    localparam int STEP_T = 2;
    logic clk_sys, sys_rst, ce, frame_valid, frame_wr, rd_valid, smp_wr, smp_err, smp_uv, bufchk_done;
    logic [6:0] frame_addr, evt;
    logic [23:0] frame_wdata, rd_data;
    logic [1:0] smp_slot;
    logic [19:0] smp_data;
    logic bcast_send, periodic_mode, channel_enable, bufchk_start, disc_start, supply_force_low;
    logic [2:0] disc_count;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    pcr_regs #(.AUTO_CYC(AUTO_T), .STEP_CYC(STEP_T)) pcr_regs_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .frame_valid(frame_valid), .frame_wr(frame_wr), .frame_addr(frame_addr),
        .frame_wdata(frame_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .smp_wr(smp_wr), .smp_slot(smp_slot), .smp_data(smp_data), .smp_err(smp_err),
        .smp_uv(smp_uv), .bufchk_done(bufchk_done),
        .evt_pll_unlock(evt[6]), .evt_ref_clock(evt[5]), .evt_gnda_open(evt[4]),
        .evt_gndd_open(evt[3]), .evt_overcurrent(evt[2]), .evt_thermal(evt[1]),
        .evt_supply_low(evt[0]), .bcast_send(bcast_send), .periodic_mode(periodic_mode),
        .channel_enable(channel_enable), .bufchk_start(bufchk_start), .disc_start(disc_start),
        .disc_count(disc_count), .supply_force_low(supply_force_low)
    );

    pcr_host_model pcr_host_model_inst (
        .clk_sys(clk_sys), .frame_valid(frame_valid), .frame_wr(frame_wr),
        .frame_addr(frame_addr), .frame_wdata(frame_wdata), .rd_data(rd_data), .rd_valid(rd_valid)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ==========================================
    // Helpers
    // ==========================================
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            close_out;
        end
    end

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [6:0] addr, input logic [23:0] exp, input string name);
        logic [23:0] d;
        logic ok;
        pcr_host_model_inst.rd(addr, d, ok);
        chk({name, " valid"}, {23'h0, ok}, 24'h1);
        chk(name, d, exp);
    endtask

    function automatic logic [6:0] slot_addr(input int i);
        return OFS_SAMPLE0 + SMP_STRIDE * 7'(i);
    endfunction

    task automatic pulse_evt(input logic [6:0] v);
        @(posedge clk_sys);
        #1;
        evt = v;
        @(posedge clk_sys);
        #1;
        evt = 7'h00;
    endtask

    task automatic wait_send(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (bcast_send !== 1'b1 && n < 200);
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic s_reset;
        rdchk(OFS_PERIODIC_COLLECTION_MODE, 24'h0, "periodic_collection_mode reset");
        rdchk(OFS_CHCTRL, 24'h0, "ctrl reset");
        for (int i = 0; i < SMP_SLOTS; i++) rdchk(slot_addr(i), 24'h0, "slot reset");
        rdchk(7'h0c, 24'h0, "unmapped");
        chk("mode outs", {18'h0, periodic_mode, channel_enable, supply_force_low, disc_count}, 24'h0);
    endtask

    task automatic s_status;
        logic [7:0] b;
        for (int i = 0; i < 7; i++) begin
            b = 8'h01 << ((i == 0) ? 0 : i + 1);
            pulse_evt(7'h01 << i);
            rdchk(OFS_CHCTRL, {16'h0, b}, "status flag");
            pcr_host_model_inst.wr(OFS_CHCTRL, 24'h0000ff);
            rdchk(OFS_CHCTRL, {16'h0, b}, "status w1 keeps");
            pcr_host_model_inst.wr(OFS_CHCTRL, 24'h000000);
            rdchk(OFS_CHCTRL, 24'h0, "status w0 clears");
        end
        pulse_evt(7'h7f);
        rdchk(OFS_CHCTRL, 24'h0000fd, "status all");
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h0000f0);
        rdchk(OFS_CHCTRL, 24'h0000f0, "status part clear");
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h000000);
    endtask

    task automatic s_supply;
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h080000);
        chk("force low", {23'h0, supply_force_low}, 24'h1);
        rdchk(OFS_CHCTRL, 24'h080001, "test sets uv");
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h000000);
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h000000);
        rdchk(OFS_CHCTRL, 24'h0, "test off");
    endtask

    task automatic s_control;
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h040500);
        chk("disc start", {23'h0, disc_start}, 24'h1);
        chk("disc count", {21'h0, disc_count}, 24'h5);
        rdchk(OFS_CHCTRL, 24'h040500, "ctrl back");
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h030300);
        chk("bufchk start", {23'h0, bufchk_start}, 24'h1);
        chk("en kept", {23'h0, channel_enable}, 24'h1);
        chk("dpc kept", {21'h0, disc_count}, 24'h5);
        chk("no disc", {23'h0, disc_start}, 24'h0);
        @(posedge clk_sys);
        #1;
        bufchk_done = 1'b1;
        @(posedge clk_sys);
        #1;
        bufchk_done = 1'b0;
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h000000);
        chk("en off", {23'h0, channel_enable}, 24'h0);
    endtask

    task automatic s_freeze;
        ce = 1'b0;
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h040300);
        pulse_evt(7'h02);
        ce = 1'b1;
        chk("frozen en", {22'h0, channel_enable, disc_start}, 24'h0);
        rdchk(OFS_CHCTRL, 24'h0, "frozen stat");
    endtask

    task automatic s_samples;
        logic [19:0] d;
        logic e, u;
        for (int i = 0; i < SMP_SLOTS; i++) begin
            d = {4'(i + 9), 16'h5a00 + 16'(i)};
            e = (i == 1);
            u = (i == 2);
            @(posedge clk_sys);
            #1;
            {smp_wr, smp_slot, smp_data, smp_err, smp_uv} = {1'b1, 2'(i), d, e, u};
            @(posedge clk_sys);
            #1;
            smp_wr = 1'b0;
            rdchk(slot_addr(i), {e, 1'b0, 1'b1, u, d}, "sample new");
            rdchk(slot_addr(i), {e, 1'b0, 1'b0, u, d}, "sample consumed");
        end
        pcr_host_model_inst.wr(slot_addr(0), 24'hffffff);
        rdchk(slot_addr(0), 24'h095a00, "sample ro");
    endtask

    task automatic s_periodic;
        int n;
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h020300);
        rdchk(OFS_PERIODIC_COLLECTION_MODE, 24'h000300, "auto ignored");
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h010300);
        chk("periodic on", {23'h0, periodic_mode}, 24'h1);
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h810300);
        wait_send(n);
        chk("manual delay", 24'(n), 24'(1 + STEP_T * 3));
        @(posedge clk_sys);
        #1;
        chk("send pulse", {23'h0, bcast_send}, 24'h0);
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h000900);
        chk("en stays", {23'h0, periodic_mode}, 24'h1);
        rdchk(OFS_PERIODIC_COLLECTION_MODE, 24'h010300, "delay locked");
        pcr_host_model_inst.wr(OFS_CHCTRL, 24'h040200);
        chk("ctrl locked", {22'h0, channel_enable, disc_start}, 24'h0);
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h030300);
        wait_send(n);
        wait_send(n);
        chk("auto period", 24'(n), 24'(AUTO_T));
        pcr_host_model_inst.wr(OFS_CLEAR, 24'hff0000);
        chk("clear leaves", {23'h0, periodic_mode}, 24'h0);
        rdchk(OFS_PERIODIC_COLLECTION_MODE, 24'h0, "clear periodic_collection_mode");
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h010000);
        pcr_host_model_inst.wr(OFS_PERIODIC_COLLECTION_MODE, 24'h810000);
        wait_send(n);
        chk("manual no delay", 24'(n), 24'h1);
        pcr_host_model_inst.wr(OFS_CLEAR, 24'hff0000);
        chk("clear again", {23'h0, periodic_mode}, 24'h0);
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        {sys_rst, ce, smp_wr, smp_err, smp_uv, bufchk_done} = 6'b110000;
        smp_slot = 2'h0;
        smp_data = 20'h00000;
        evt = 7'h00;
        repeat (6) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        s_reset;
        s_status;
        s_supply;
        s_control;
        s_freeze;
        s_samples;
        s_periodic;
        close_out;
    end
endmodule
